// ===== inc/i2cc_defines.svh
`ifndef I2CC_DEFINES_SVH
`define I2CC_DEFINES_SVH
// register byte offsets
`define I2CC_OFS_DATA     16'ha000
`define I2CC_OFS_STATUS   16'ha008
`define I2CC_OFS_OWNADDR  16'ha00c
`define I2CC_OFS_CONTROL  16'ha014
`define I2CC_OFS_SCLLOW   16'ha018
`define I2CC_OFS_SCLHIGH  16'ha01c
`define I2CC_OFS_SDAHOLD  16'ha020
// reset values
`define I2CC_RST_DATA     8'hff
`define I2CC_RST_SCLLOW   16'hffff
`define I2CC_RST_SCLHIGH  16'hffff
`define I2CC_RST_SDAHOLD  15'h7fff
// status bit positions
`define I2CC_SR_ADDR_ACK_OR_GENERAL_CALL     7
`define I2CC_SR_DONE      6
`define I2CC_SR_STOP      5
`define I2CC_SR_SSEL      4
`define I2CC_SR_LOST      3
`define I2CC_SR_BUSY      2
`define I2CC_SR_TRANSMIT_DIRECTION_FLAG      1
`define I2CC_SR_ACK_RECEIVED_FLAG     0
// control bit positions
`define I2CC_CR_IPF       7
`define I2CC_CR_SRST      5
`define I2CC_CR_INTERRUPT_ENABLE     4
`define I2CC_CR_RECEIVE_ACK_ENABLE     3
`define I2CC_CR_STOP      1
`define I2CC_CR_START     0
// fixed extra clocks added to the programmed durations
`define I2CC_LOW_EXTRA    16'h0002
`define I2CC_HIGH_EXTRA   16'h0003
`define I2CC_HOLD_EXTRA   15'h0004
`endif

// ===== inc/i2cc_pkg.sv
package i2cc_pkg;
  // master bit engine phases, one-hot
  typedef enum logic [5:0] {
    I2CC_IDLE  = 6'b00_0001,
    I2CC_START = 6'b00_0010,
    I2CC_LOW   = 6'b00_0100,
    I2CC_HIGH  = 6'b00_1000,
    I2CC_WAIT  = 6'b01_0000,
    I2CC_STOP  = 6'b10_0000
  } i2cc_state_t;
endpackage

// ===== verilog/i2cc_ctrl.sv
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "i2cc_defines.svh"
module i2cc_ctrl
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // bus lines, open drain
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // processor interrupt
  output logic             irq
);

  i2cc_pkg::i2cc_state_t state;
  logic [7:0]  data_byte;
  logic [7:0]  own_addr;
  logic [7:0]  ctrl;
  logic [15:0] scl_low_cfg;
  logic [15:0] scl_high_cfg;
  logic [14:0] sda_hold_cfg;
  logic f_addr_ack_or_general_call, f_done, f_stop, f_ssel, f_lost, f_busy, f_transmit_direction_flag, f_ack_received_flag;
  logic [1:0]  scl_sync;
  logic [1:0]  sda_sync;
  logic        scl_q, sda_q;
  logic [15:0] cnt;
  logic [3:0]  bitn;          // 0..7 data bits, 8 is ack
  logic        addr_phase;
  logic        pull_scl, pull_sda;
  logic        s_act, s_tx, s_addr;
  logic [7:0]  s_shift;
  logic [3:0]  s_bit;

  wire ev_wr_sr   = reg_wr && reg_addr == `I2CC_OFS_STATUS;
  wire ev_wr_cr   = reg_wr && reg_addr == `I2CC_OFS_CONTROL;
  wire ev_wr_dr   = reg_wr && reg_addr == `I2CC_OFS_DATA;
  wire soft_rst   = ctrl[`I2CC_CR_SRST];
  wire scl_rise   = scl_sync[1] && !scl_q;
  wire scl_fall   = !scl_sync[1] && scl_q;
  wire start_seen = scl_sync[1] && scl_q && sda_q && !sda_sync[1];
  wire stop_seen  = scl_sync[1] && scl_q && !sda_q && sda_sync[1];
  wire hold_scl   = ctrl[`I2CC_CR_IPF] && !f_stop;
  wire m_act      = state != i2cc_pkg::I2CC_IDLE;
  wire m_tx_bit   = addr_phase || f_transmit_direction_flag;
  wire m_drive_sda = bitn == 4'd8 ? (!m_tx_bit && ctrl[`I2CC_CR_RECEIVE_ACK_ENABLE])
                                 : (m_tx_bit && !data_byte[3'd7 - bitn[2:0]]);
  wire [6:0] s_addr_rx = s_shift[6:0];
  wire s_match = s_addr_rx == own_addr[7:1];
  wire s_addr_ack_or_general_call = s_addr_rx == 7'h00 && own_addr[0];

  // input synchronisers; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end
    else if (clk_en)
    begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      own_addr     <= 8'h00;
      scl_low_cfg  <= `I2CC_RST_SCLLOW;
      scl_high_cfg <= `I2CC_RST_SCLHIGH;
      sda_hold_cfg <= `I2CC_RST_SDAHOLD;
    end
    else if (clk_en && reg_wr)
    begin
      case (reg_addr)
        `I2CC_OFS_OWNADDR: own_addr     <= reg_wdata[7:0];
        `I2CC_OFS_SCLLOW:  scl_low_cfg  <= reg_wdata;
        `I2CC_OFS_SCLHIGH: scl_high_cfg <= reg_wdata;
        `I2CC_OFS_SDAHOLD: sda_hold_cfg <= reg_wdata[14:0];
        default: ;
      endcase
    end
  end

  // control register; interrupt flag set by events wins over software clear
  logic ev_irq;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ctrl <= 8'h00;
    else if (clk_en)
    begin
      if (ev_wr_cr)
        ctrl <= {reg_wdata[7], 1'b0, reg_wdata[5:3], 1'b0, reg_wdata[1:0]};
      else if (ev_wr_sr)
        ctrl[`I2CC_CR_IPF] <= 1'b0;
      if (state == i2cc_pkg::I2CC_STOP || f_lost)
        ctrl[`I2CC_CR_START] <= 1'b0;
      if (soft_rst)
        ctrl[`I2CC_CR_SRST] <= 1'b0;
      if (ev_irq)
        ctrl[`I2CC_CR_IPF] <= 1'b1;
    end
  end

  // master engine: timing, shifting, arbitration
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state      <= i2cc_pkg::I2CC_IDLE;
      cnt        <= 16'h0000;
      bitn       <= 4'h0;
      addr_phase <= 1'b0;
      pull_scl   <= 1'b0;
      pull_sda   <= 1'b0;
    end
    else if (clk_en)
    begin
      if (soft_rst)
      begin
        state    <= i2cc_pkg::I2CC_IDLE;
        pull_scl <= 1'b0;
        pull_sda <= 1'b0;
      end
      else
      begin
        case (state)
          i2cc_pkg::I2CC_IDLE:
          begin
            pull_scl <= 1'b0;
            pull_sda <= 1'b0;
            if (ctrl[`I2CC_CR_START] && !f_busy && !hold_scl)
            begin
              state      <= i2cc_pkg::I2CC_START;
              pull_sda   <= 1'b1;
              cnt        <= scl_high_cfg + `I2CC_HIGH_EXTRA;
              addr_phase <= 1'b1;
              bitn       <= 4'h0;
            end
          end
          i2cc_pkg::I2CC_START:
          begin
            if (cnt != 16'h0000)
              cnt <= cnt - 16'h0001;
            else
            begin
              pull_scl <= 1'b1;
              state    <= i2cc_pkg::I2CC_LOW;
              cnt      <= scl_low_cfg + `I2CC_LOW_EXTRA;
            end
          end
          i2cc_pkg::I2CC_LOW:
          begin
            // data changes after the hold time has elapsed in the low phase
            if ((scl_low_cfg + `I2CC_LOW_EXTRA - cnt) == {1'b0, sda_hold_cfg + `I2CC_HOLD_EXTRA})
              pull_sda <= m_drive_sda;
            if (cnt != 16'h0000)
              cnt <= cnt - 16'h0001;
            else if (!hold_scl)
            begin
              pull_sda <= m_drive_sda;
              pull_scl <= 1'b0;
              state    <= i2cc_pkg::I2CC_WAIT;
            end
          end
          i2cc_pkg::I2CC_WAIT:
          begin
            // clock synchronisation: high phase counts once the line rises
            if (scl_sync[1])
            begin
              state <= i2cc_pkg::I2CC_HIGH;
              cnt   <= scl_high_cfg + `I2CC_HIGH_EXTRA;
            end
          end
          i2cc_pkg::I2CC_HIGH:
          begin
            if (pull_sda == 1'b0 && !sda_sync[1] && bitn != 4'd8 && m_tx_bit)
            begin
              pull_sda <= 1'b0;
              state    <= i2cc_pkg::I2CC_IDLE;
            end
            else if (cnt != 16'h0000)
              cnt <= cnt - 16'h0001;
            else if (bitn == 4'd8)
            begin
              bitn       <= 4'h0;
              addr_phase <= 1'b0;
              pull_scl   <= 1'b1;
              if ((m_tx_bit && (sda_sync[1] || ctrl[`I2CC_CR_STOP])) ||
                  (!m_tx_bit && ctrl[`I2CC_CR_STOP]))
              begin
                pull_sda <= 1'b1;
                state    <= i2cc_pkg::I2CC_STOP;
                cnt      <= scl_low_cfg + `I2CC_LOW_EXTRA;
              end
              else
              begin
                state <= i2cc_pkg::I2CC_LOW;
                cnt   <= scl_low_cfg + `I2CC_LOW_EXTRA;
              end
            end
            else
            begin
              bitn     <= bitn + 4'h1;
              pull_scl <= 1'b1;
              state    <= i2cc_pkg::I2CC_LOW;
              cnt      <= scl_low_cfg + `I2CC_LOW_EXTRA;
            end
          end
          i2cc_pkg::I2CC_STOP:
          begin
            // low, release clock, then release data while clock is high
            if (cnt != 16'h0000)
              cnt <= cnt - 16'h0001;
            else if (pull_scl)
            begin
              // the byte flag is already pending here, so keep stretching
              if (!hold_scl)
              begin
                pull_scl <= 1'b0;
                cnt      <= scl_high_cfg + `I2CC_HIGH_EXTRA;
              end
            end
            else
            begin
              pull_sda <= 1'b0;
              state    <= i2cc_pkg::I2CC_IDLE;
            end
          end
          default: state <= i2cc_pkg::I2CC_IDLE;
        endcase
      end
    end
  end

  // slave receiver/transmitter shift logic
  logic s_pull_sda;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_act      <= 1'b0;
      s_tx       <= 1'b0;
      s_addr     <= 1'b0;
      s_shift    <= 8'h00;
      s_bit      <= 4'h0;
      s_pull_sda <= 1'b0;
    end
    else if (clk_en)
    begin
      if (soft_rst || stop_seen)
      begin
        s_act      <= 1'b0;
        s_pull_sda <= 1'b0;
      end
      else if (start_seen)
      begin
        s_act  <= !m_act;
        s_addr <= 1'b1;
        s_bit  <= 4'h0;
      end
      else if (s_act && scl_rise && s_bit != 4'd8)
      begin
        s_shift <= {s_shift[6:0], sda_sync[1]};
        s_bit   <= s_bit + 4'h1;
      end
      else if (s_act && scl_rise)
        s_bit <= 4'h0;
      else if (s_act && scl_fall)
      begin
        if (s_bit == 4'd8 && s_addr)
        begin
          s_pull_sda <= s_match || s_addr_ack_or_general_call;
          s_tx       <= s_shift[0] && s_match;
          s_act      <= s_match || s_addr_ack_or_general_call;
        end
        else if (s_bit == 4'd8)
          s_pull_sda <= !s_tx && ctrl[`I2CC_CR_RECEIVE_ACK_ENABLE];
        else if (s_tx && !hold_scl)
          s_pull_sda <= !data_byte[3'd7 - s_bit[2:0]];
        else
          s_pull_sda <= 1'b0;
        if (s_bit == 4'h0)
          s_addr <= 1'b0;
      end
    end
  end

  // status flags and data register; hardware sets win over clear
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      data_byte <= `I2CC_RST_DATA;
      {f_addr_ack_or_general_call, f_done, f_stop, f_ssel, f_lost, f_busy, f_transmit_direction_flag, f_ack_received_flag} <= 8'h00;
      ev_irq    <= 1'b0;
    end
    else if (clk_en)
    begin
      ev_irq <= 1'b0;
      if (ev_wr_sr)
        {f_done, f_stop, f_ssel, f_lost, f_ack_received_flag} <= 5'h00;
      if (ev_wr_dr)
        data_byte <= reg_wdata[7:0];
      if (start_seen)
        f_busy <= 1'b1;
      if (stop_seen)
      begin
        f_busy <= 1'b0;
        f_stop <= 1'b1;
        ev_irq <= 1'b1;
      end
      if (m_act && state == i2cc_pkg::I2CC_HIGH && cnt == 16'h0000 && bitn == 4'd8)
      begin
        f_done  <= 1'b1;
        f_ack_received_flag <= m_tx_bit && !sda_sync[1];
        if (addr_phase)
        begin
          f_addr_ack_or_general_call <= !sda_sync[1];
          f_transmit_direction_flag  <= !data_byte[0];
        end
        ev_irq  <= 1'b1;
      end
      if (state == i2cc_pkg::I2CC_HIGH && m_tx_bit && bitn != 4'd8 && !pull_sda &&
          !sda_sync[1] && m_drive_sda == 1'b0)
      begin
        f_lost <= 1'b1;
        ev_irq <= 1'b1;
      end
      if (s_act && scl_rise && s_bit == 4'd7 && !s_addr)
        data_byte <= {s_shift[6:0], sda_sync[1]};
      if (s_act && scl_fall && s_bit == 4'd8)
      begin
        f_done <= 1'b1;
        ev_irq <= 1'b1;
        if (s_addr && (s_match || s_addr_ack_or_general_call))
        begin
          f_ssel  <= 1'b1;
          f_addr_ack_or_general_call <= s_addr_ack_or_general_call && !s_match;
          f_transmit_direction_flag  <= s_shift[0] && s_match;
        end
      end
      if (m_act && state == i2cc_pkg::I2CC_LOW && bitn == 4'd8 && addr_phase)
        f_transmit_direction_flag <= !data_byte[0];
    end
  end

  // outputs and register read port, all registered
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata <= 16'h0000;
      scl_out   <= 1'b0;
      scl_oe    <= 1'b0;
      sda_out   <= 1'b0;
      sda_oe    <= 1'b0;
      irq       <= 1'b0;
    end
    else if (clk_en)
    begin
      scl_oe  <= pull_scl || (s_act && hold_scl && !scl_sync[1]);
      sda_oe  <= pull_sda || s_pull_sda;
      irq     <= ctrl[`I2CC_CR_IPF] && ctrl[`I2CC_CR_INTERRUPT_ENABLE];
      reg_rdata <= 16'h0000;
      if (reg_rd)
      begin
        case (reg_addr)
          `I2CC_OFS_DATA:    reg_rdata <= {8'h00, data_byte};
          `I2CC_OFS_STATUS:  reg_rdata <= {8'h00, f_addr_ack_or_general_call, f_done, f_stop, f_ssel,
                                           f_lost, f_busy, f_transmit_direction_flag, f_ack_received_flag};
          `I2CC_OFS_OWNADDR: reg_rdata <= {8'h00, own_addr};
          `I2CC_OFS_CONTROL: reg_rdata <= {8'h00, ctrl};
          `I2CC_OFS_SCLLOW:  reg_rdata <= scl_low_cfg;
          `I2CC_OFS_SCLHIGH: reg_rdata <= scl_high_cfg;
          `I2CC_OFS_SDAHOLD: reg_rdata <= {1'b0, sda_hold_cfg};
          default:           reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule // i2cc_ctrl
`default_nettype wire

// ===== sim/i2cc_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2cc_defines.svh"
module i2cc_ctrl_props
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        clk_en,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // bus lines
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  // interrupt
  input wire logic        irq
);
  logic [16:0] lo_cnt;
  logic [16:0] hi_cnt;
  logic [16:0] lo_val;
  logic [16:0] hi_val;
  logic [16:0] hd_val;
  logic        st_wr;
  assign st_wr = reg_wr && (reg_addr == `I2CC_OFS_STATUS);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // shadow durations; only lower bounds, since stretching may lengthen a phase
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lo_val <= 17'h0_ffff;
      hi_val <= 17'h0_ffff;
      hd_val <= 17'h0_7fff;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `I2CC_OFS_SCLLOW) lo_val <= {1'b0, reg_wdata};
      if (reg_addr == `I2CC_OFS_SCLHIGH) hi_val <= {1'b0, reg_wdata};
      if (reg_addr == `I2CC_OFS_SDAHOLD) hd_val <= {2'b00, reg_wdata[14:0]};
    end
  end
  // cycles the clock line has been pulled low, saturating
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b) lo_cnt <= 17'h0_0000;
    else if (!scl_oe) lo_cnt <= 17'h0_0000;
    else if (lo_cnt != 17'h1_ffff) lo_cnt <= lo_cnt + 17'h0_0001;
  end
  // cycles the clock line has been released, saturating
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b) hi_cnt <= 17'h0_0000;
    else if (scl_oe) hi_cnt <= 17'h0_0000;
    else if (hi_cnt != 17'h1_ffff) hi_cnt <= hi_cnt + 17'h0_0001;
  end
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside answer cycle");
  open_drain_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("bus line driven high");
  irq_clear_a: assert property (st_wr |-> ##[1:2] !irq)
    else $error("status write left request up");
  irq_mask_a: assert property (reg_wr && reg_addr == `I2CC_OFS_CONTROL && !reg_wdata[4]
    |-> ##[1:2] !irq)
    else $error("request up with enable off");
  clk_hold_a: assert property (irq && scl_oe && !reg_wr |=> scl_oe)
    else $error("clock released while flag pending");
  clk_free_a: assert property (irq && scl_oe && st_wr |-> ##[1:12] !scl_oe)
    else $error("clock not released after status write");
  low_time_a: assert property ($fell(scl_oe) |-> lo_cnt >= lo_val + 17'h0_0003)
    else $error("clock low phase too short");
  high_time_a: assert property ($rose(scl_oe) |-> hi_cnt >= hi_val + 17'h0_0003)
    else $error("clock high phase too short");
  data_hold_a: assert property ($changed(sda_oe) && scl_oe && $past(scl_oe)
    |-> lo_cnt >= hd_val + 17'h0_0003)
    else $error("data changed before hold time");
  cover property ($rose(irq));
  cover property (st_wr && scl_oe);
  cover property ($rose(sda_oe) && !scl_oe);
endmodule // i2cc_ctrl_props
bind i2cc_ctrl i2cc_ctrl_props u_props (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
`default_nettype wire

// ===== sim/i2cc_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2cc_slave_model
(
  // wire levels
  input  wire logic       scl,
  input  wire logic       sda,
  // answer select
  input  wire logic       ack_en,
  // pull and received byte
  output logic            sda_pull,
  output logic      [7:0] rx_byte
);
  int bit_n;
  initial
  begin
    sda_pull = 1'b0;
    rx_byte  = 8'h00;
    bit_n    = 0;
  end
  // data edge with clock high is start or stop: reframe and let go
  always @(sda)
  begin
    if (scl === 1'b1)
    begin
      bit_n    = 0;
      sda_pull = 1'b0;
    end
  end
  // bits taken msb first on the rising clock, ninth clock is the answer slot
  always @(posedge scl)
  begin
    if (bit_n < 8)
    begin
      rx_byte = {rx_byte[6:0], sda};
      bit_n   = bit_n + 1;
    end
    else
      bit_n = 9;
  end
  // only ever pulls low, and takes up the pull only while the clock is low
  always @(negedge scl)
  begin
    sda_pull = (bit_n == 8) && ack_en;
    if (bit_n == 9) bit_n = 0;
  end
endmodule // i2cc_slave_model
`default_nettype wire

// ===== sim/i2c_master_slave_controller_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2cc_defines.svh"
module i2c_master_slave_controller_tb_top;
  logic        clk;
  logic        rst_b;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        scl_out, scl_oe, sda_out, sda_oe, irq;
  logic        sda_pull;
  logic        ack_en;
  logic [7:0]  rx_byte;
  wire logic   scl_w;
  wire logic   sda_w;
  int          failures;
  int          checks;
  localparam logic [15:0] RA [8] = '{`I2CC_OFS_DATA, `I2CC_OFS_STATUS, `I2CC_OFS_OWNADDR,
    `I2CC_OFS_CONTROL, `I2CC_OFS_SCLLOW, `I2CC_OFS_SCLHIGH, `I2CC_OFS_SDAHOLD, 16'ha004};
  localparam logic [15:0] RV [8] = '{16'h00ff, 16'h0000, 16'h0000, 16'h0000, 16'hffff,
    16'hffff, 16'h7fff, 16'h0000};
  // pull-ups on both lines, wired-and of all pulls
  assign scl_w = scl_oe ? scl_out : 1'b1;
  assign sda_w = (sda_oe ? sda_out : 1'b1) & !sda_pull;
  initial clk = 1'b0;
  always #50 clk = ~clk;
  i2cc_ctrl DUT (.clk(clk), .rst_b(rst_b), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
  i2cc_slave_model u_slave (.scl(scl_w), .sda(sda_w), .ack_en(ack_en),
    .sda_pull(sda_pull), .rx_byte(rx_byte));
  task automatic results();
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  // answer stands in the cycle after the strobe; taken mid-cycle where it is settled
  task automatic rd(input string n, input logic [15:0] a, input logic [15:0] m,
    input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    chk(n, e, reg_rdata & m);
  endtask
  // settle first so a request being cleared is not mistaken for a new one
  task automatic wait_irq();
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    while (irq !== 1'b1 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000)
    begin
      failures++;
      results();
    end
  endtask
  initial
  begin
    rst_b = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ack_en = 1'b1;
    failures = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd("reset value", RA[i], 16'hffff, RV[i]);
    wr(`I2CC_OFS_OWNADDR, 16'h00a5);
    rd("own address", `I2CC_OFS_OWNADDR, 16'h00ff, 16'h00a5);
    wr(`I2CC_OFS_SCLLOW, 16'h0004);
    wr(`I2CC_OFS_SCLHIGH, 16'h0004);
    wr(`I2CC_OFS_SDAHOLD, 16'h0000);
    rd("clock low", `I2CC_OFS_SCLLOW, 16'hffff, 16'h0004);
    // acknowledged address byte, stop asked for up front
    wr(`I2CC_OFS_DATA, 16'h00a4);
    rd("data byte", `I2CC_OFS_DATA, 16'h00ff, 16'h00a4);
    wr(`I2CC_OFS_CONTROL, 16'h0013);
    wait_irq();
    chk("sent byte", 16'h00a4, {8'h00, rx_byte});
    rd("status after ack", `I2CC_OFS_STATUS, 16'h00c7, 16'h00c7);
    chk("irq level", 16'h0001, {15'h0000, irq});
    wr(`I2CC_OFS_STATUS, 16'h0000);
    wait_irq();
    rd("status after stop", `I2CC_OFS_STATUS, 16'h007d, 16'h0020);
    wr(`I2CC_OFS_CONTROL, 16'h0000);
    rd("control cleared", `I2CC_OFS_CONTROL, 16'h00ff, 16'h0000);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    wr(`I2CC_OFS_STATUS, 16'h0000);
    // refused address: no ack seen, stop follows without control bit1
    ack_en <= 1'b0;
    wr(`I2CC_OFS_DATA, 16'h0052);
    wr(`I2CC_OFS_CONTROL, 16'h0019);
    wait_irq();
    rd("status after nack", `I2CC_OFS_STATUS, 16'h00c3, 16'h0042);
    wr(`I2CC_OFS_STATUS, 16'h0000);
    wait_irq();
    rd("stop after nack", `I2CC_OFS_STATUS, 16'h0025, 16'h0020);
    wr(`I2CC_OFS_STATUS, 16'h0000);
    // soft reset bit does not stick
    wr(`I2CC_OFS_CONTROL, 16'h0020);
    rd("soft reset", `I2CC_OFS_CONTROL, 16'h0020, 16'h0000);
    results();
  end
endmodule // i2c_master_slave_controller_tb_top
`default_nettype wire
